// >>> rtl/jack_sense_pkg.sv
/*
  Constants and carrier types for the jack sense detail register bank.
  Assumes the codec register interface presents one-cycle read/write
  strobes with a 7-bit register index and 16-bit data on mclk_in.
*/
package jack_sense_pkg;

  // ==========================================================
  // Register map
  localparam logic [6:0] PAGE_SEL_OFS      = 7'h24;
  localparam logic [6:0] SENSE_FUNC_OFS    = 7'h68;
  localparam logic [6:0] SENSE_DETAILS_OFS = 7'h6a;
  localparam logic [3:0] PAGE_SENSE        = 4'h1;
  localparam logic [3:0] PAGE_SEL_RST      = 4'h0;

  // ==========================================================
  // Field positions
  localparam int LOC_LSB    = 13;
  localparam int TYPE_LSB   = 8;
  localparam int SCALE_LSB  = 6;
  localparam int RESULT_LSB = 0;
  localparam int VALID_BIT  = 4;
  localparam int FIP_BIT    = 0;

  // ==========================================================
  // Field codes and reset values
  localparam logic [2:0] LOC_REAR     = 3'h0;
  localparam logic [2:0] LOC_FRONT    = 3'h1;
  localparam logic [2:0] LOC_BOARD    = 3'h2;
  localparam logic [2:0] LOC_DOCK     = 3'h3;
  localparam logic [2:0] LOC_UNUSED   = 3'h7;
  localparam logic [2:0] LOC_RST      = 3'h7;
  localparam logic [4:0] TYPE_INVALID = 5'h00;
  localparam logic [4:0] TYPE_NONE    = 5'h01;
  localparam logic [4:0] TYPE_FPRINT  = 5'h02;
  localparam logic [4:0] TYPE_OTHER   = 5'h0a;
  localparam logic [4:0] TYPE_UNKNOWN = 5'h0f;
  localparam logic [1:0] SCALE_RST    = 2'h0;
  localparam logic [5:0] RESULT_RST   = 6'h00;
  localparam logic       FIP_VALUE    = 1'b1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       is_output;
    logic [4:0] kind;
    logic [1:0] scale;
    logic [5:0] value;
  } sense_res_s;

endpackage

// >>> rtl/jack_sense_detail_register.sv
/*
  Sense detail register (6Ah, page 01h) with the page select register
  and the valid/presence bits of the neighbouring sense function
  register. Only the location field is writable; type, scale and result
  are captured from the sensing unit and are read only. Unmapped indices
  and the paged registers on any other page read as zero.
  Assumes the sensing unit delivers a one-cycle done pulse on mclk_in
  with its classified result; the result input is the unit's own logic
  and needs no synchroniser. Read and write strobes arrive on the same
  clock, one cycle wide, and may follow one another back to back.
  No interrupt is raised; software polls the valid flag.
*/
// Overview of operation
// - Register 6Ah decodes to this block only while page select 24h is 01h.
// - Bits 15-13 hold a writable jack location, 0 rear to 3 dock, 7 unused.
// - Bits 12-8 report the sensed type, read only, per output or input table.
// - Output jacks report codes 0-6, 9, Ah, Fh; others are reserved.
// - Input jacks report codes 0-3, 5, 9, Ah, Fh; others are reserved.
// - Bits 7-6 give the decimal scale of the result, 1 to 1000 ohms.
// - Bits 5-0 report a read-only six-bit measured value or fingerprint.
// - A read-only presence bit in the sense function register reads 1.
// - Writing 1 clears the valid flag, 0 has no effect; sense done sets it, or clears it if the type is invalid.
`timescale 1ns/1ps
module jack_sense_detail_register
  import jack_sense_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire reg_req_s    req_in,
  input  wire logic        sense_done_in,
  input  wire sense_res_s  sense_res_in,
  output logic [15:0]      rdata_out,
  output logic             rvalid_out,
  output logic [2:0]       jack_location_out,
  output logic             sense_valid_flag_out
);

  // ==========================================================
  // State
  logic [3:0] page_r,       page_nxt;
  logic [2:0] location_r,   location_nxt;
  logic [4:0] kind_r,       kind_nxt;
  logic [1:0] scale_r,      scale_nxt;
  logic [5:0] value_r,      value_nxt;
  logic       valid_r,      valid_nxt;
  logic       sensed_r,     sensed_nxt;
  logic [15:0] rdata_r,     rdata_nxt;
  logic       rvalid_r,     rvalid_nxt;

  logic       on_sense_page;
  logic       hit_details;
  logic       hit_func;
  logic [4:0] kind_checked;

  assign on_sense_page = (page_r == PAGE_SENSE);
  assign hit_details   = on_sense_page &&
                         (req_in.addr == SENSE_DETAILS_OFS);
  assign hit_func      = on_sense_page &&
                         (req_in.addr == SENSE_FUNC_OFS);

  // ==========================================================
  // Reserved sensed codes collapse to unknown, so software never sees
  // a code that neither table defines
  always_comb begin
    kind_checked = TYPE_UNKNOWN;
    if (sense_res_in.is_output) begin
      case (sense_res_in.kind)
        5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
        5'h09, 5'h0a, 5'h0f: kind_checked = sense_res_in.kind;
        default:             kind_checked = TYPE_UNKNOWN;
      endcase
    end else begin
      case (sense_res_in.kind)
        5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
        5'h09, 5'h0a, 5'h0f: kind_checked = sense_res_in.kind;
        default:             kind_checked = TYPE_UNKNOWN;
      endcase
    end
  end

  // ==========================================================
  // Page select
  // Sits outside the paged window, so it is reachable on every page
  always_comb begin
    page_nxt = page_r;
    if (req_in.wr && req_in.addr == PAGE_SEL_OFS) begin
      page_nxt = req_in.wdata[3:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      page_r <= PAGE_SEL_RST;
    end else begin
      page_r <= page_nxt;
    end
  end

  // ==========================================================
  // Jack location, the only writable field of the details word
  // Reserved codes 4 to 6 are kept as written; software owns them
  always_comb begin
    location_nxt = location_r;
    if (req_in.wr && hit_details) begin
      location_nxt = req_in.wdata[LOC_LSB +: 3];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      location_r <= LOC_RST;
    end else begin
      location_r <= location_nxt;
    end
  end

  // ==========================================================
  // Sense result capture; software writes to these fields are dropped
  always_comb begin
    kind_nxt   = kind_r;
    scale_nxt  = scale_r;
    value_nxt  = value_r;
    sensed_nxt = sensed_r;
    if (sense_done_in) begin
      kind_nxt   = kind_checked;
      scale_nxt  = sense_res_in.scale;
      value_nxt  = sense_res_in.value;
      sensed_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      kind_r   <= TYPE_INVALID;
      scale_r  <= SCALE_RST;
      value_r  <= RESULT_RST;
      sensed_r <= 1'b0;
    end else begin
      kind_r   <= kind_nxt;
      scale_r  <= scale_nxt;
      value_r  <= value_nxt;
      sensed_r <= sensed_nxt;
    end
  end

  // ==========================================================
  // Valid flag: write one to clear, set by a completed sense
  // A sense that ends with invalid contents leaves the flag clear
  always_comb begin
    valid_nxt = valid_r;
    if (req_in.wr && hit_func && req_in.wdata[VALID_BIT]) begin
      valid_nxt = 1'b0;
    end
    // Set placed after clear so a completing sense wins the race
    if (sense_done_in) begin
      valid_nxt = (kind_checked != TYPE_INVALID);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  // ==========================================================
  // Read words, assembled field by field from the stored state
  // Reserved bits read as zero in every word
  logic [15:0] page_word;
  logic [15:0] details_word;
  logic [15:0] func_word;

  always_comb begin
    page_word                     = 16'h0000;
    page_word[3:0]                = page_r;
    details_word                  = 16'h0000;
    details_word[LOC_LSB +: 3]    = location_r;
    details_word[TYPE_LSB +: 5]   = sensed_r ? kind_r
                                             : TYPE_INVALID;
    details_word[SCALE_LSB +: 2]  = scale_r;
    details_word[RESULT_LSB +: 6] = value_r;
    func_word                     = 16'h0000;
    func_word[VALID_BIT]          = valid_r;
    func_word[FIP_BIT]            = FIP_VALUE;
  end

  // ==========================================================
  // Read path: registered data, one cycle after the read strobe
  // Page select answers on every page; only 68h and 6Ah are gated
  always_comb begin
    rdata_nxt  = 16'h0000;
    rvalid_nxt = req_in.rd;
    if (req_in.rd) begin
      if (req_in.addr == PAGE_SEL_OFS) begin
        rdata_nxt = page_word;
      end else if (hit_details) begin
        rdata_nxt = details_word;
      end else if (hit_func) begin
        rdata_nxt = func_word;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_out            = rdata_r;
  assign rvalid_out           = rvalid_r;
  assign jack_location_out    = location_r;
  assign sense_valid_flag_out = valid_r;

endmodule

// >>> bench/jack_sense_chk.sv
/* Port checker for the sense detail bank.
   Assumes it is bound to jack_sense_detail_register. */
`timescale 1ns/1ps
module jack_sense_chk
  import jack_sense_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire reg_req_s    req_in,
  input  wire logic        sense_done_in,
  input  wire sense_res_s  sense_res_in,
  input  wire logic [15:0] rdata_out,
  input  wire logic        rvalid_out,
  input  wire logic [2:0]  jack_location_out,
  input  wire logic        sense_valid_flag_out
);
  // ==========
  // Shadow of page select and first sense
  logic [3:0] page_r, page_nxt;
  logic       seen_r, seen_nxt, pg, a6, a8;
  assign pg = page_r == PAGE_SENSE;
  assign a6 = req_in.addr == SENSE_DETAILS_OFS;
  assign a8 = req_in.addr == SENSE_FUNC_OFS;
  always_comb begin
    page_nxt = (req_in.wr && req_in.addr == PAGE_SEL_OFS) ?
               req_in.wdata[3:0] : page_r;
    seen_nxt = seen_r | sense_done_in;
  end
  always_ff @(posedge mclk_in) begin
    page_r <= resetn_in ? page_nxt : PAGE_SEL_RST;
    seen_r <= resetn_in & seen_nxt;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // ==========
  // Properties
  a_read_answer: assert property (req_in.rd |=> rvalid_out)
    else $error("read not answered");
  a_idle_zero: assert property (!rvalid_out |-> rdata_out == 16'h0000)
    else $error("read data not cleared");
  a_page_gate: assert property (req_in.rd && !pg && (a6 || a8)
    |=> rdata_out == 16'h0000) else $error("page gate open");
  a_loc_write: assert property (req_in.wr && a6 && pg
    |=> jack_location_out == $past(req_in.wdata[15:13]))
    else $error("location not written");
  a_loc_hold: assert property (!(req_in.wr && a6 && pg)
    |=> $stable(jack_location_out)) else $error("location moved");
  a_loc_read: assert property (req_in.rd && a6 && pg
    |=> rdata_out[15:13] == $past(jack_location_out))
    else $error("location read wrong");
  a_type_invalid: assert property (req_in.rd && a6 && pg && !seen_r
    |=> rdata_out[12:8] == TYPE_INVALID) else $error("stale type");
  a_func_read: assert property (req_in.rd && a8 && pg |=> rdata_out ==
    {11'h000, $past(sense_valid_flag_out), 3'h0, FIP_VALUE})
    else $error("function word wrong");
  a_valid_clear: assert property (req_in.wr && a8 && pg &&
    req_in.wdata[VALID_BIT] && !sense_done_in |=> !sense_valid_flag_out)
    else $error("valid not cleared");
  a_valid_set: assert property (sense_done_in &&
    sense_res_in.kind != TYPE_INVALID |=> sense_valid_flag_out)
    else $error("valid not set");
  c_read: cover property (req_in.rd && a6 && pg);
  c_set: cover property ($rose(sense_valid_flag_out));
  c_clear: cover property ($fell(sense_valid_flag_out));
endmodule

// >>> bench/sense_model.sv
/* Sensing unit stand-in: pulses done with one result.
   Assumes the bench calls fire from its own thread. */
`timescale 1ns/1ps
module sense_model
  import jack_sense_pkg::*;
(
  input  wire logic  mclk_in,
  output logic       done_out,
  output sense_res_s res_out
);
  // ==========
  // Result is scrambled outside done so stale reads cannot pass
  initial begin
    done_out = 1'b0;
    res_out = '0;
  end
  task automatic fire(input sense_res_s r);
    @(posedge mclk_in);
    #1 done_out = 1'b1;
    res_out = r;
    @(posedge mclk_in);
    #1 done_out = 1'b0;
    res_out = ~r;
  endtask
endmodule

// >>> bench/jack_sense_detail_register_tb.sv
/* Self-checking bench for the sense detail bank.
   Assumes sense_model as the sensing unit and the port checker. */
`timescale 1ns/1ps
module jack_sense_detail_register_tb
  import jack_sense_pkg::*;
;
  // ==========
  // Harness
  logic        mclk_in = 1'b0, resetn_in = 1'b0, done, rv, vf;
  reg_req_s    req_in = '0;
  sense_res_s  res, r;
  logic [15:0] rd, e, d;
  logic [2:0]  loc;
  logic        sv;
  logic [2:0]  locs[5] = '{LOC_REAR, LOC_FRONT, LOC_BOARD, LOC_DOCK,
                           LOC_UNUSED};
  logic [15:0] q[$];
  int          miscompares = 0, n_tests = 0, seed = 32'h6653;
  always #2.5 mclk_in = ~mclk_in;
  jack_sense_detail_register dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .req_in(req_in), .sense_done_in(done), .sense_res_in(res),
    .rdata_out(rd), .rvalid_out(rv), .jack_location_out(loc),
    .sense_valid_flag_out(vf));
  sense_model sm_u (.mclk_in(mclk_in), .done_out(done), .res_out(res));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // On reads the data word carries the expected answer
  task automatic op(input logic w, rdq, input logic [6:0] a,
                    input logic [15:0] v);
    @(posedge mclk_in);
    #1 req_in = '{wr: w, rd: rdq, addr: a, wdata: v};
    if (rdq) q.push_back(v);
  endtask
  function automatic logic [4:0] ek(input sense_res_s s);
    logic [15:0] m;
    m = s.is_output ? 16'h867f : 16'h862f;
    return (s.kind < 5'h10 && m[s.kind[3:0]]) ? s.kind : TYPE_UNKNOWN;
  endfunction
  always @(posedge mclk_in) begin
    if (rv === 1'b1) chk(rd, q.pop_front());
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #10000 miscompares++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge mclk_in);
    #1 resetn_in = 1'b1;
    op(0, 1, SENSE_DETAILS_OFS, 16'h0000);
    op(1, 0, SENSE_DETAILS_OFS, 16'h2000);
    op(1, 0, PAGE_SEL_OFS, 16'h0001);
    op(0, 1, SENSE_DETAILS_OFS, 16'he000);
    op(0, 1, SENSE_FUNC_OFS, 16'h0001);
    $display("test reset and page done");
    foreach (locs[i]) begin
      d = 16'($random(seed));
      d[15:13] = locs[i];
      op(1, 0, SENSE_DETAILS_OFS, d);
      op(0, 1, SENSE_DETAILS_OFS, {locs[i], 13'h0000});
      chk(16'(loc), 16'(locs[i]));
    end
    $display("test location done");
    for (int i = 0; i < 64; i++) begin
      r.is_output = i[5];
      r.kind = (i[4:0] == 5'h00 && i[5]) ? 5'h10 : i[4:0];
      {r.scale, r.value} = 8'($random(seed));
      e = {LOC_UNUSED, ek(r), r.scale, r.value};
      sv = (ek(r) != TYPE_INVALID);
      op(0, 0, 7'h00, 16'h0000);
      sm_u.fire(r);
      chk(16'(vf), 16'(sv));
      op(0, 1, SENSE_DETAILS_OFS, e);
      op(1, 0, SENSE_FUNC_OFS, {11'h000, i[0], 4'h0});
      op(0, 1, SENSE_FUNC_OFS, {11'h000, sv & !i[0], 4'h1});
    end
    $display("test sense done");
    op(0, 1, 7'h10, 16'h0000);
    op(1, 0, PAGE_SEL_OFS, 16'h0000);
    op(0, 1, SENSE_DETAILS_OFS, 16'h0000);
    op(1, 0, SENSE_DETAILS_OFS, 16'h0000);
    op(1, 0, PAGE_SEL_OFS, 16'h0001);
    op(0, 1, SENSE_DETAILS_OFS, e);
    op(0, 0, 7'h00, 16'h0000);
    repeat (3) @(posedge mclk_in);
    chk(16'(q.size()), 16'h0000);
    $display("test page return done");
    close_out();
  end
endmodule
bind jack_sense_detail_register jack_sense_chk chk_u (.mclk_in(mclk_in),
  .resetn_in(resetn_in), .req_in(req_in), .sense_done_in(sense_done_in),
  .sense_res_in(sense_res_in), .rdata_out(rdata_out),
  .rvalid_out(rvalid_out), .jack_location_out(jack_location_out),
  .sense_valid_flag_out(sense_valid_flag_out));
